//--- hw/i2c_rx_pkg.sv
package i2c_rx_pkg;

    // clock of the block and the least half period of the bus clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int BUS_HALF_PERIOD_NS = 5000;
    // least time rounds up to whole cycles
    localparam int HALF_PERIOD_CYCLES = (BUS_HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // byte framing
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
    localparam logic [3:0] BIT_RESET = 4'h0;
    localparam logic [7:0] BUFFER_RESET = 8'h00;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_ADDR = 3'b010,
        ST_RECV = 3'b011,
        ST_ACK = 3'b100,
        ST_STOP = 3'b101
    } state_t;

endpackage

//--- hw/baud_if.sv
`timescale 1ns/1ns
interface baud_if;
    logic run;
    logic rollover;
    modport gen (input run, output rollover);
    modport ctl (output run, input rollover);
endinterface

//--- hw/baud_gen.sv
`timescale 1ns/1ns
module baud_gen #(
    parameter int RELOAD = i2c_rx_pkg::HALF_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // controller side
    baud_if.gen baud
);
    localparam int CW = $clog2(RELOAD + 1);

    initial begin
        if (RELOAD < 2) begin
            $error("baud_gen: RELOAD must be at least 2");
        end
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_rollover;

    // counter restarts whenever the controller holds it, so a stretched clock restarts the phase
    always_comb begin
        next_count = '0;
        next_rollover = 1'b0;
        if (baud.run) begin
            if (count == CW'(RELOAD - 1)) begin
                next_rollover = 1'b1;
            end else begin
                next_count = CW'(count + 1'b1);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= '0;
            baud.rollover <= 1'b0;
        end else begin
            count <= next_count;
            baud.rollover <= next_rollover;
        end
    end

endmodule // baud_gen

//--- hw/i2c_master_receive.sv
// Operation
// (RULE_01) receive enable ignored unless port idle
// (RULE_02) each rollover toggles clock, shifts bit in
// (RULE_03) eighth fall: store byte, flags, hold clock
// (RULE_04) after byte, idle until next command
// (RULE_05) buffer full set on address/data load; the code sets it only when a received byte is stored
// (RULE_06) buffer read clears buffer full
// (RULE_07) byte while buffer full sets overflow
// (RULE_08) write during transfer discarded, sets collision
// (RULE_09) start request; flag set when start done
// (RULE_10) software loads address with read bit
// (RULE_11) buffer write shifts address out, msb first
// (RULE_12) slave acknowledge sampled into ack status
// (RULE_13) flag set after ninth address clock
// (RULE_14) acknowledge sequence drives selected value
// (RULE_15) flag set when acknowledge clocked out
// (RULE_16) software repeats per byte, ends transfer
// (RULE_17) msb first, received bytes double buffered
// (RULE_18) collision must clear before writes work
// (RULE_19) sample data while clock high, honour stretching
`timescale 1ns/1ns
module i2c_master_receive #(
    parameter int HALF_CYCLES = i2c_rx_pkg::HALF_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // software commands, one-cycle pulses
    input wire logic start_condition_enable_in,
    input wire logic stop_condition_enable_in,
    input wire logic receive_enable_cmd_in,
    input wire logic ack_sequence_enable_in,
    input wire logic ack_value_select_in,
    input wire logic buffer_write_in,
    input wire logic [7:0] buffer_write_data_in,
    input wire logic buffer_read_in,
    input wire logic irq_flag_clear_in,
    input wire logic write_collision_clear_in,
    input wire logic overflow_clear_in,
    // status
    output logic [7:0] serial_buffer_out,
    output logic buffer_full_flag_out,
    output logic serial_irq_flag_out,
    output logic receive_overflow_flag_out,
    output logic write_collision_flag_out,
    output logic slave_ack_status_out,
    output logic receive_enable_cmd_out,
    // open-drain bus pins
    input wire logic bus_clock_pin_in,
    output logic bus_clock_pin_out,
    output logic bus_clock_pin_oe_out,
    input wire logic bus_data_pin_in,
    output logic bus_data_pin_out,
    output logic bus_data_pin_oe_out
);
    baud_if baud ();

    baud_gen #(
        .RELOAD(HALF_CYCLES)
    ) u_baud (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .baud(baud)
    );

    i2c_rx_pkg::state_t state, next_state;
    logic scl_meta, scl_sync, sda_meta, sda_sync;
    logic [7:0] shift, next_shift, next_buffer;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic step, next_step;
    logic ack_value, next_ack_value;
    logic next_scl_oe, next_sda_oe, next_ack_status, next_receive_enable_cmd;
    logic next_bf, next_irq, next_ov, next_write_collision_flag;
    logic byte_done, irq_set, write_collision_flag_set;
    logic [3:0] bit_inc;

    // pins cross in through two flops; the bus idles high
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= bus_clock_pin_in;
            scl_sync <= scl_meta;
            sda_meta <= bus_data_pin_in;
            sda_sync <= sda_meta;
        end
    end

    // a released clock that still reads low is a slave stretching: restart the count
    assign baud.run = (state != i2c_rx_pkg::ST_IDLE) && (bus_clock_pin_oe_out || scl_sync); // RULE_19
    assign bit_inc = 4'(bit_cnt + 4'h1);

    // sequencer, shifter and flags
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_buffer = serial_buffer_out;
        next_bit_cnt = bit_cnt;
        next_step = step;
        next_ack_value = ack_value;
        next_scl_oe = bus_clock_pin_oe_out;
        next_sda_oe = bus_data_pin_oe_out;
        next_ack_status = slave_ack_status_out;
        next_receive_enable_cmd = receive_enable_cmd_out;
        byte_done = 1'b0;
        irq_set = 1'b0;
        write_collision_flag_set = 1'b0;
        case (state)
            i2c_rx_pkg::ST_IDLE: begin
                // clock stays where the last operation left it
                if (buffer_write_in && !write_collision_flag_out) begin // RULE_18
                    next_buffer = buffer_write_data_in;
                    next_shift = buffer_write_data_in;
                    next_sda_oe = !buffer_write_data_in[7]; // RULE_11
                    next_bit_cnt = i2c_rx_pkg::BIT_RESET;
                    next_state = i2c_rx_pkg::ST_ADDR;
                end else if (start_condition_enable_in) begin
                    next_scl_oe = 1'b0;
                    next_sda_oe = 1'b0;
                    next_step = 1'b0;
                    next_state = i2c_rx_pkg::ST_START;
                end else if (stop_condition_enable_in) begin
                    next_sda_oe = 1'b1;
                    next_step = 1'b0;
                    next_state = i2c_rx_pkg::ST_STOP;
                end else if (receive_enable_cmd_in) begin // RULE_01
                    next_receive_enable_cmd = 1'b1;
                    next_sda_oe = 1'b0;
                    next_bit_cnt = i2c_rx_pkg::BIT_RESET;
                    next_state = i2c_rx_pkg::ST_RECV;
                end else if (ack_sequence_enable_in) begin
                    next_ack_value = ack_value_select_in;
                    next_sda_oe = !ack_value_select_in; // RULE_14
                    next_bit_cnt = i2c_rx_pkg::BIT_RESET;
                    next_state = i2c_rx_pkg::ST_ACK;
                end
            end
            i2c_rx_pkg::ST_START: begin
                if (baud.rollover) begin
                    if (!step) begin
                        next_sda_oe = 1'b1; // data falls while clock high
                        next_step = 1'b1;
                    end else begin
                        next_scl_oe = 1'b1;
                        irq_set = 1'b1; // RULE_09
                        next_state = i2c_rx_pkg::ST_IDLE;
                    end
                end
            end
            i2c_rx_pkg::ST_STOP: begin
                if (baud.rollover) begin
                    if (!step) begin
                        next_scl_oe = 1'b0;
                        next_step = 1'b1;
                    end else begin
                        next_sda_oe = 1'b0; // data rises while clock high
                        irq_set = 1'b1;
                        next_state = i2c_rx_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                // address, receive and acknowledge share one bit engine
                if (baud.rollover) begin
                    if (bus_clock_pin_oe_out) begin
                        next_scl_oe = 1'b0; // RULE_02
                    end else begin
                        next_scl_oe = 1'b1; // RULE_02
                        next_shift = {shift[6:0], sda_sync}; // RULE_17
                        next_bit_cnt = bit_inc;
                        if (state == i2c_rx_pkg::ST_ADDR) begin
                            if (bit_cnt == i2c_rx_pkg::ACK_BIT_INDEX) begin
                                next_ack_status = sda_sync; // RULE_12
                                irq_set = 1'b1; // RULE_13
                                next_state = i2c_rx_pkg::ST_IDLE;
                            end else if (bit_inc == i2c_rx_pkg::DATA_BITS) begin
                                next_sda_oe = 1'b0; // release for the slave acknowledge
                            end else begin
                                next_sda_oe = !shift[6]; // RULE_11
                            end
                        end else if (state == i2c_rx_pkg::ST_RECV) begin
                            if (bit_inc == i2c_rx_pkg::DATA_BITS) begin
                                byte_done = 1'b1;
                                next_buffer = {shift[6:0], sda_sync}; // RULE_03
                                irq_set = 1'b1; // RULE_03
                                next_receive_enable_cmd = 1'b0; // RULE_03
                                next_state = i2c_rx_pkg::ST_IDLE; // RULE_04
                            end
                        end else begin
                            irq_set = 1'b1; // RULE_15
                            next_state = i2c_rx_pkg::ST_IDLE;
                        end
                    end
                end
            end
        endcase
        // a write that meets a transfer or an uncleared collision is dropped
        write_collision_flag_set = buffer_write_in && ((state != i2c_rx_pkg::ST_IDLE) || write_collision_flag_out); // RULE_08
        if (state != i2c_rx_pkg::ST_IDLE && !byte_done) begin
            next_buffer = serial_buffer_out; // RULE_08
        end
        // set wins over clear on every flag
        next_bf = (buffer_full_flag_out && !buffer_read_in) || byte_done; // RULE_05 RULE_06
        next_ov = (receive_overflow_flag_out && !overflow_clear_in) || (byte_done && buffer_full_flag_out); // RULE_07
        next_irq = (serial_irq_flag_out && !irq_flag_clear_in) || irq_set;
        next_write_collision_flag = (write_collision_flag_out && !write_collision_clear_in) || write_collision_flag_set;
    end

    // register stage; pin drive levels stay low, only the enables move
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= i2c_rx_pkg::ST_IDLE;
            shift <= i2c_rx_pkg::BUFFER_RESET;
            serial_buffer_out <= i2c_rx_pkg::BUFFER_RESET;
            bit_cnt <= i2c_rx_pkg::BIT_RESET;
            step <= 1'b0;
            ack_value <= 1'b0;
            bus_clock_pin_oe_out <= 1'b0;
            bus_data_pin_oe_out <= 1'b0;
            bus_clock_pin_out <= 1'b0;
            bus_data_pin_out <= 1'b0;
            slave_ack_status_out <= 1'b0;
            receive_enable_cmd_out <= 1'b0;
            buffer_full_flag_out <= 1'b0;
            receive_overflow_flag_out <= 1'b0;
            serial_irq_flag_out <= 1'b0;
            write_collision_flag_out <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            serial_buffer_out <= next_buffer;
            bit_cnt <= next_bit_cnt;
            step <= next_step;
            ack_value <= next_ack_value;
            bus_clock_pin_oe_out <= next_scl_oe;
            bus_data_pin_oe_out <= next_sda_oe;
            bus_clock_pin_out <= 1'b0;
            bus_data_pin_out <= 1'b0;
            slave_ack_status_out <= next_ack_status;
            receive_enable_cmd_out <= next_receive_enable_cmd;
            buffer_full_flag_out <= next_bf;
            receive_overflow_flag_out <= next_ov;
            serial_irq_flag_out <= next_irq;
            write_collision_flag_out <= next_write_collision_flag;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    receive_enable_cmd_ignore_a: assert property ((state != i2c_rx_pkg::ST_IDLE) && receive_enable_cmd_in
        && (state != i2c_rx_pkg::ST_RECV) |=> (state != i2c_rx_pkg::ST_RECV)) // RULE_01
        else $error("receive enable taken while busy");
    recv_end_a: assert property (($past(state) == i2c_rx_pkg::ST_RECV) && (state == i2c_rx_pkg::ST_IDLE)
        |-> buffer_full_flag_out && serial_irq_flag_out && !receive_enable_cmd_out && bus_clock_pin_oe_out) // RULE_03
        else $error("receive end did not post byte");
    bf_read_a: assert property (buffer_read_in && !byte_done |=> !buffer_full_flag_out) // RULE_06
        else $error("buffer read did not clear full");
    overflow_set_a: assert property (byte_done && buffer_full_flag_out |=> receive_overflow_flag_out) // RULE_07
        else $error("overflow not flagged");
    write_collision_flag_keep_a: assert property (buffer_write_in && (state != i2c_rx_pkg::ST_IDLE) && !byte_done
        |=> write_collision_flag_out && $stable(serial_buffer_out)) // RULE_08
        else $error("colliding write not dropped");
    addr_bit_a: assert property ((state == i2c_rx_pkg::ST_ADDR) && !bus_clock_pin_oe_out
        && (bit_cnt < i2c_rx_pkg::DATA_BITS) |-> (bus_data_pin_oe_out == !shift[7])) // RULE_11
        else $error("address bit wrong on data pin");
    ack_sample_a: assert property ((state == i2c_rx_pkg::ST_ADDR) && baud.rollover && !bus_clock_pin_oe_out
        && (bit_cnt == i2c_rx_pkg::ACK_BIT_INDEX) |=> (slave_ack_status_out == $past(sda_sync))
        && serial_irq_flag_out) // RULE_12
        else $error("slave acknowledge not stored");
    start_done_a: assert property (($past(state) == i2c_rx_pkg::ST_START) && (state == i2c_rx_pkg::ST_IDLE)
        |-> serial_irq_flag_out && bus_data_pin_oe_out && bus_clock_pin_oe_out) // RULE_09
        else $error("start end not flagged");
    ack_drive_a: assert property ((state == i2c_rx_pkg::ST_ACK) |-> (bus_data_pin_oe_out == !ack_value)) // RULE_14
        else $error("acknowledge value not driven");
    stretch_hold_a: assert property ((state != i2c_rx_pkg::ST_IDLE) && !bus_clock_pin_oe_out && !scl_sync
        |=> !baud.rollover) // RULE_19
        else $error("counted through a stretched clock");

endmodule // i2c_master_receive

//--- testbench/i2c_slave_model.sv
`timescale 1ns/1ns
module i2c_slave_model #(
    parameter logic [6:0] ADDR = 7'h2d,
    parameter logic [7:0] TX_FIRST = 8'hc3
) (
    // bus lines as resolved by the bench
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic stretch_in,
    // open-drain pulls, high pulls the line low
    output logic scl_oe_out,
    output logic sda_oe_out,
    // what the model saw
    output logic [7:0] addr_seen_out,
    output logic master_ack_out
);
    logic [1:0] phase; // 0 idle, 1 address, 2 sending
    int cnt;
    logic [7:0] tx;
    initial begin
        phase = 2'd0;
        cnt = 0;
        tx = TX_FIRST;
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
        addr_seen_out = 8'h00;
        master_ack_out = 1'b1;
    end
    // start and stop seen as data edges while the clock is high; the short wait lets a clock fall
    // in the same time step settle first, so a data change right at the fall is not taken for one
    always @(negedge sda_in) begin
        #1;
        if (scl_in) begin
            phase = 2'd1;
            cnt = 0;
            tx = TX_FIRST;
        end
    end
    always @(posedge sda_in) begin
        #1;
        if (scl_in) phase = 2'd0;
    end
    // sample on the rising clock: address bits msb first, master ack on ninth
    always @(posedge scl_in) begin
        if (phase == 2'd1 && cnt < 8) addr_seen_out = {addr_seen_out[6:0], sda_in};
        if (phase == 2'd2 && cnt == 8) master_ack_out = sda_in;
        cnt++;
    end
    // change data only while the clock is low; a nack ends sending so a stop can follow
    always @(negedge scl_in) begin
        if (phase == 2'd1 && cnt == 9) begin
            phase = (addr_seen_out[7:1] == ADDR && addr_seen_out[0]) ? 2'd2 : 2'd0;
            cnt = 0;
        end else if (phase == 2'd2 && cnt == 9) begin
            phase = master_ack_out ? 2'd0 : 2'd2;
            cnt = 0;
            tx = ~tx;
        end
        sda_oe_out = (phase == 2'd2 && cnt < 8) ? !tx[7 - cnt] : (phase == 2'd1 && cnt == 8 && addr_seen_out[7:1] == ADDR);
        // stretching holds the clock low a while after each fall
        if (stretch_in) begin
            scl_oe_out = 1'b1;
            scl_oe_out <= #300 1'b0;
        end
    end
endmodule // i2c_slave_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam logic [6:0] slave_addr = 7'h2d;
    localparam logic [7:0] first_byte = 8'hc3;
    localparam int c_start = 0, c_stop = 1, c_recv = 2, c_ack = 3, c_wr = 4, c_rd = 5, c_irq = 6, c_write_collision_flag = 7, c_ovf = 8;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [8:0] cmd = 9'h000;
    logic ack_value = 1'b0;
    logic stretch = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] buffer, addr_seen;
    logic full, irq, ovf, write_collision_flag, ackst, rcv, clk_oe, dat_oe, s_clk_oe, s_dat_oe, master_ack;
    logic clk_lvl, dat_lvl;
    wire scl = !(clk_oe | s_clk_oe);
    wire sda = !(dat_oe | s_dat_oe);
    int mismatches = 0;
    int tests_run = 0;

    always #10 sys_clk_in = ~sys_clk_in;

    i2c_master_receive #(.HALF_CYCLES(4)) dut_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .start_condition_enable_in(cmd[c_start]), .stop_condition_enable_in(cmd[c_stop]),
        .receive_enable_cmd_in(cmd[c_recv]), .ack_sequence_enable_in(cmd[c_ack]),
        .ack_value_select_in(ack_value), .buffer_write_in(cmd[c_wr]), .buffer_write_data_in(wdata),
        .buffer_read_in(cmd[c_rd]), .irq_flag_clear_in(cmd[c_irq]),
        .write_collision_clear_in(cmd[c_write_collision_flag]), .overflow_clear_in(cmd[c_ovf]),
        .serial_buffer_out(buffer), .buffer_full_flag_out(full), .serial_irq_flag_out(irq),
        .receive_overflow_flag_out(ovf), .write_collision_flag_out(write_collision_flag),
        .slave_ack_status_out(ackst), .receive_enable_cmd_out(rcv),
        .bus_clock_pin_in(scl), .bus_clock_pin_out(clk_lvl), .bus_clock_pin_oe_out(clk_oe),
        .bus_data_pin_in(sda), .bus_data_pin_out(dat_lvl), .bus_data_pin_oe_out(dat_oe));

    i2c_slave_model #(.ADDR(slave_addr), .TX_FIRST(first_byte)) slave_u (
        .scl_in(scl), .sda_in(sda), .stretch_in(stretch), .scl_oe_out(s_clk_oe),
        .sda_oe_out(s_dat_oe), .addr_seen_out(addr_seen), .master_ack_out(master_ack));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // commands are one-cycle pulses launched at the falling edge
    task automatic pulse(input int idx);
        @(negedge sys_clk_in);
        cmd[idx] = 1'b1;
        @(negedge sys_clk_in);
        cmd[idx] = 1'b0;
    endtask

    // bounded wait for the flag, then clear it as software would
    task automatic wait_irq(input string name);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(negedge sys_clk_in);
            n++;
        end
        check(name, {7'h00, irq}, 8'h01);
        pulse(c_irq);
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog well beyond the several hundred cycles the sequence needs
    initial begin
        #400_000;
        mismatches++;
        $display("unexpected timeout: expected finish, seen hang");
        stop_test();
    end

    initial begin
        repeat (3) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        check("buffer at reset", buffer, 8'h00);
        check("flags at reset", {1'b0, full, irq, ovf, write_collision_flag, ackst, rcv, clk_oe | dat_oe}, 8'h00);
        $display("test reset done");
        // start, address with read bit, a colliding write and a refused receive
        pulse(c_start);
        wait_irq("start irq");
        check("start lines", {6'h00, scl, sda}, 8'h00);
        wdata = {slave_addr, 1'b1};
        pulse(c_wr);
        wdata = 8'h00;
        pulse(c_wr);
        pulse(c_recv);
        check("collision", {7'h00, write_collision_flag}, 8'h01);
        check("receive ignored", {7'h00, rcv}, 8'h00);
        wait_irq("address irq");
        check("address on wire", addr_seen, {slave_addr, 1'b1});
        check("slave ack", {7'h00, ackst}, 8'h00);
        // an idle write while the collision flag stands must not start a transfer
        pulse(c_wr);
        check("write refused", {6'h00, write_collision_flag, dat_oe}, 8'h02);
        check("buffer kept", buffer, {slave_addr, 1'b1});
        pulse(c_write_collision_flag);
        $display("test address done");
        // three bytes: unread first gives overflow, last under stretching and nacked
        for (int k = 0; k < 3; k++) begin
            stretch = (k == 2);
            pulse(c_recv);
            if (k == 0) begin
                check("receiving", {7'h00, rcv}, 8'h01);
                pulse(c_wr);
                check("receive collision", {7'h00, write_collision_flag}, 8'h01);
                pulse(c_write_collision_flag);
            end
            wait_irq("byte irq");
            check("byte", buffer, (k == 1) ? ~first_byte : first_byte);
            check("byte status", {5'h00, full, rcv, clk_oe}, 8'h05);
            if (k == 0) begin
                repeat (40) @(negedge sys_clk_in);
                check("held idle", {6'h00, scl, clk_oe}, 8'h01);
            end else begin
                if (k == 1) check("overflow", {7'h00, ovf}, 8'h01);
                pulse(c_rd);
                pulse(c_ovf);
                check("full cleared", {6'h00, full, ovf}, 8'h00);
            end
            ack_value = (k == 2);
            pulse(c_ack);
            wait_irq("ack irq");
            check("ack on wire", {7'h00, master_ack}, {7'h00, ack_value});
            $display("test byte %0d done", k);
        end
        stretch = 1'b0;
        pulse(c_stop);
        wait_irq("stop irq");
        check("lines after stop", {2'b00, clk_lvl, dat_lvl, scl, sda, clk_oe, dat_oe}, 8'h0c);
        // unanswered address after the collision was cleared
        pulse(c_start);
        wait_irq("second start irq");
        wdata = {~slave_addr, 1'b1};
        pulse(c_wr);
        wait_irq("second address irq");
        check("write after clear", buffer, {~slave_addr, 1'b1});
        check("slave nack", {7'h00, ackst}, 8'h01);
        pulse(c_stop);
        wait_irq("second stop irq");
        $display("test nack address done");
        stop_test();
    end
endmodule // tb_top
